// ---- rtl/spsum_chan.sv ----
`timescale 1ns/1ps
`default_nettype none
module spsum_chan (
  spsum_chan_if.calc ch
);
  import spsum_pkg::*;

  logic signed [SPS_PW-1:0] prod;
  logic signed [SPS_PW-1:0] dvs;
  logic signed [SPS_PW-1:0] quot;
  logic signed [SPS_PW-1:0] lim;

  // ==========================================================
  // Scale, guard zero divisor, clamp
  // ==========================================================
  // Both factors carry four decimals, so the ratio keeps the operand format
  always_comb begin
    prod = SPS_PW'(ch.operand) * SPS_PW'(ch.gain);
    dvs  = SPS_PW'(ch.divisor);
    lim  = SPS_PW'(ch.bound);
    quot = '0;
    if (ch.divisor != '0) begin
      quot = prod / dvs;
    end
    if (ch.divisor == '0) begin
      ch.scaled = '0;
    end else if (quot > lim) begin
      ch.scaled = ch.bound;
    end else if (quot < -lim) begin
      ch.scaled = -ch.bound;
    end else begin
      ch.scaled = quot[SPS_VW-1:0];
    end
  end
endmodule
`default_nettype wire

// ---- rtl/spsum_chan_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface spsum_chan_if;
  import spsum_pkg::*;

  spsum_val_t operand;
  spsum_val_t gain;
  spsum_val_t divisor;
  spsum_val_t bound;
  spsum_val_t scaled;

  modport calc (input operand, input gain, input divisor, input bound, output scaled);
  modport user (output operand, output gain, output divisor, output bound, input scaled);
endinterface
`default_nettype wire

// ---- rtl/spsum_pkg.sv ----
package spsum_pkg;

  // ==========================================================
  // Widths and fixed-point formats
  // ==========================================================
  // Operands and bounds in 0.01 % steps, gains and divisors in 0.0001 steps
  localparam int unsigned SPS_VW = 17;
  localparam int unsigned SPS_PW = 2 * SPS_VW;
  localparam int unsigned SPS_SW = SPS_VW + 3;
  localparam int unsigned SPS_AW = 8;
  localparam int unsigned SPS_DW = 32;
  localparam int unsigned SPS_NCH = 2;

  typedef logic signed [SPS_VW-1:0] spsum_val_t;
  typedef logic [SPS_AW-1:0]        spsum_addr_t;
  typedef logic [SPS_DW-1:0]        spsum_data_t;
  typedef logic [SPS_NCH-1:0]       spsum_pol_t;

  // ==========================================================
  // Ranges
  // ==========================================================
  localparam spsum_val_t SPS_VAL_MAX   = 17'sh07530;
  localparam spsum_val_t SPS_VAL_MIN   = -SPS_VAL_MAX;
  localparam spsum_val_t SPS_BOUND_MAX = 17'sh04E20;
  localparam spsum_val_t SPS_BOUND_MIN = 17'sh00000;

  // ==========================================================
  // Register offsets (byte addresses)
  // ==========================================================
  localparam spsum_addr_t SPS_OFF_OPA   = 8'h00;
  localparam spsum_addr_t SPS_OFF_OPB   = 8'h04;
  localparam spsum_addr_t SPS_OFF_OPC   = 8'h08;
  localparam spsum_addr_t SPS_OFF_GAINA = 8'h0C;
  localparam spsum_addr_t SPS_OFF_GAINB = 8'h10;
  localparam spsum_addr_t SPS_OFF_DIVA  = 8'h14;
  localparam spsum_addr_t SPS_OFF_DIVB  = 8'h18;
  localparam spsum_addr_t SPS_OFF_POL   = 8'h1C;
  localparam spsum_addr_t SPS_OFF_BOUND = 8'h20;
  localparam spsum_addr_t SPS_OFF_SUM   = 8'h24;
  localparam spsum_addr_t SPS_OFF_CHA   = 8'h28;
  localparam spsum_addr_t SPS_OFF_CHB   = 8'h2C;

  // ==========================================================
  // Field positions and reset values
  // ==========================================================
  localparam int unsigned SPS_POL_A_BIT = 0;
  localparam int unsigned SPS_POL_B_BIT = 1;
  localparam spsum_pol_t  SPS_POL_RST   = 2'h3;
  localparam spsum_val_t  SPS_OP_RST    = 17'sh00000;
  localparam spsum_val_t  SPS_GAIN_RST  = 17'sh02710;
  localparam spsum_val_t  SPS_DIV_RST   = 17'sh02710;
  localparam spsum_val_t  SPS_BOUND_RST = SPS_BOUND_MAX;
  localparam spsum_data_t SPS_DATA_ZERO = 32'h00000000;

  // Saturate a written word into a field range
  function automatic spsum_val_t spsum_sat(input logic signed [SPS_DW-1:0] v,
                                           input spsum_val_t lo,
                                           input spsum_val_t hi);
    spsum_val_t r;
    if (v > SPS_DW'(hi)) begin
      r = hi;
    end else if (v < SPS_DW'(lo)) begin
      r = lo;
    end else begin
      r = v[SPS_VW-1:0];
    end
    return r;
  endfunction

endpackage

// ---- rtl/spsum_top.sv ----
// Notes on behaviour
// - Operands a and b each pass their own gain, divisor, polarity path.
// - A zero divisor forces that channel's scaled result to zero.
// - Operand c joins the sum unscaled, unsigned-off and unclamped.
// - Clamp bound is symmetric, 0 to 200 %, on channels and total.
// - sum_result is the clamped total of both channels plus operand c.
// - channel_b_scaled is operand_b times gain_b over divisor_b, clamped.
// - channel_a_scaled is operand_a times gain_a over divisor_a, clamped.
// - Gains and divisors are signed, four decimals, -3 to +3.
// - Per-channel polarity; negative inverts that channel's contribution.
`timescale 1ns/1ps
`default_nettype none
module spsum_top (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire spsum_pkg::spsum_addr_t paddr,
  input  wire spsum_pkg::spsum_data_t pwdata,
  output logic                      pready,
  output logic                      pslverr,
  output spsum_pkg::spsum_data_t    prdata,
  output spsum_pkg::spsum_val_t     sum_result,
  output spsum_pkg::spsum_val_t     channel_a_scaled,
  output spsum_pkg::spsum_val_t     channel_b_scaled
);
  import spsum_pkg::*;

  // ==========================================================
  // Settings
  // ==========================================================
  spsum_val_t  operand_ff   [SPS_NCH];
  spsum_val_t  gain_ff      [SPS_NCH];
  spsum_val_t  div_ff       [SPS_NCH];
  spsum_val_t  nxt_operand  [SPS_NCH];
  spsum_val_t  nxt_gain     [SPS_NCH];
  spsum_val_t  nxt_div      [SPS_NCH];
  spsum_val_t  operand_c_ff;
  spsum_val_t  nxt_operand_c;
  spsum_pol_t  pol_ff;
  spsum_pol_t  nxt_pol;
  spsum_val_t  bound_ff;
  spsum_val_t  nxt_bound;
  spsum_data_t prdata_ff;
  spsum_data_t nxt_prdata;
  logic        slverr_ff;
  logic        nxt_slverr;

  logic signed [SPS_DW-1:0] wval;
  logic                     wr_en;
  logic                     setup;

  // Zero-wait slave: the access phase always completes in one cycle
  assign pready  = 1'b1;
  assign pslverr = slverr_ff;
  assign prdata  = prdata_ff;
  assign wval    = pwdata;
  assign wr_en   = psel && penable && pwrite;
  assign setup   = psel && !penable;

  always_comb begin
    nxt_operand   = operand_ff;
    nxt_gain      = gain_ff;
    nxt_div       = div_ff;
    nxt_operand_c = operand_c_ff;
    nxt_pol       = pol_ff;
    nxt_bound     = bound_ff;
    if (wr_en) begin
      // Out-of-range writes saturate instead of wrapping; polarity keeps only its low bits
      case (paddr)
        SPS_OFF_OPA:   nxt_operand[0] = spsum_sat(wval, SPS_VAL_MIN, SPS_VAL_MAX);
        SPS_OFF_OPB:   nxt_operand[1] = spsum_sat(wval, SPS_VAL_MIN, SPS_VAL_MAX);
        SPS_OFF_OPC:   nxt_operand_c  = spsum_sat(wval, SPS_VAL_MIN, SPS_VAL_MAX);
        SPS_OFF_GAINA: nxt_gain[0]    = spsum_sat(wval, SPS_VAL_MIN, SPS_VAL_MAX);
        SPS_OFF_GAINB: nxt_gain[1]    = spsum_sat(wval, SPS_VAL_MIN, SPS_VAL_MAX);
        SPS_OFF_DIVA:  nxt_div[0]     = spsum_sat(wval, SPS_VAL_MIN, SPS_VAL_MAX);
        SPS_OFF_DIVB:  nxt_div[1]     = spsum_sat(wval, SPS_VAL_MIN, SPS_VAL_MAX);
        SPS_OFF_POL:   nxt_pol        = pwdata[SPS_NCH-1:0];
        SPS_OFF_BOUND: nxt_bound      = spsum_sat(wval, SPS_BOUND_MIN, SPS_BOUND_MAX);
        default:       nxt_pol        = pol_ff;
      endcase
    end
  end

  // ==========================================================
  // Read path, captured in the setup phase
  // ==========================================================
  always_comb begin
    nxt_prdata = prdata_ff;
    // Set at setup, cleared as the access completes: one cycle wide
    nxt_slverr = 1'b0;
    if (setup) begin
      nxt_slverr = 1'b0;
      case (paddr)
        SPS_OFF_OPA:   nxt_prdata = SPS_DW'(operand_ff[0]);
        SPS_OFF_OPB:   nxt_prdata = SPS_DW'(operand_ff[1]);
        SPS_OFF_OPC:   nxt_prdata = SPS_DW'(operand_c_ff);
        SPS_OFF_GAINA: nxt_prdata = SPS_DW'(gain_ff[0]);
        SPS_OFF_GAINB: nxt_prdata = SPS_DW'(gain_ff[1]);
        SPS_OFF_DIVA:  nxt_prdata = SPS_DW'(div_ff[0]);
        SPS_OFF_DIVB:  nxt_prdata = SPS_DW'(div_ff[1]);
        SPS_OFF_POL:   nxt_prdata = {{(SPS_DW-SPS_NCH){1'b0}}, pol_ff};
        SPS_OFF_BOUND: nxt_prdata = SPS_DW'(bound_ff);
        SPS_OFF_SUM:   nxt_prdata = SPS_DW'(sum_result);
        SPS_OFF_CHA:   nxt_prdata = SPS_DW'(channel_a_scaled);
        SPS_OFF_CHB:   nxt_prdata = SPS_DW'(channel_b_scaled);
        default: begin
          nxt_prdata = SPS_DATA_ZERO;
          nxt_slverr = 1'b1;
        end
      endcase
    end
  end

  // All state is local, so copies never interfere
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < SPS_NCH; i++) begin
        operand_ff[i] <= SPS_OP_RST;
        gain_ff[i]    <= SPS_GAIN_RST;
        div_ff[i]     <= SPS_DIV_RST;
      end
      operand_c_ff <= SPS_OP_RST;
      pol_ff       <= SPS_POL_RST;
      bound_ff     <= SPS_BOUND_RST;
      prdata_ff    <= SPS_DATA_ZERO;
      slverr_ff    <= 1'b0;
    end else begin
      operand_ff   <= nxt_operand;
      gain_ff      <= nxt_gain;
      div_ff       <= nxt_div;
      operand_c_ff <= nxt_operand_c;
      pol_ff       <= nxt_pol;
      bound_ff     <= nxt_bound;
      prdata_ff    <= nxt_prdata;
      slverr_ff    <= nxt_slverr;
    end
  end

  // ==========================================================
  // Channels and sum
  // ==========================================================
  spsum_val_t chan_scaled [SPS_NCH];
  spsum_val_t chan_term   [SPS_NCH];
  spsum_val_t chan_ff     [SPS_NCH];
  spsum_val_t nxt_chan    [SPS_NCH];
  spsum_val_t sum_ff;
  spsum_val_t nxt_sum;
  logic signed [SPS_SW-1:0] total;
  logic signed [SPS_SW-1:0] total_lim;

  spsum_chan_if ch_if [SPS_NCH] ();

  for (genvar g = 0; g < SPS_NCH; g++) begin : gen_chan
    assign ch_if[g].operand = operand_ff[g];
    assign ch_if[g].gain    = gain_ff[g];
    assign ch_if[g].divisor = div_ff[g];
    assign ch_if[g].bound   = bound_ff;
    assign chan_scaled[g]   = ch_if[g].scaled;
    // Bound is at most 200 %, so negation cannot overflow
    assign chan_term[g]     = pol_ff[g] ? chan_scaled[g] : -chan_scaled[g];
    spsum_chan u_chan (
      .ch (ch_if[g].calc)
    );
  end

  always_comb begin
    nxt_chan  = chan_scaled;
    total_lim = SPS_SW'(bound_ff);
    // Wide adder: three 300 % terms cannot wrap before the clamp
    total     = SPS_SW'(chan_term[0]) + SPS_SW'(chan_term[1]) + SPS_SW'(operand_c_ff);
    if (total > total_lim) begin
      nxt_sum = bound_ff;
    end else if (total < -total_lim) begin
      nxt_sum = -bound_ff;
    end else begin
      nxt_sum = total[SPS_VW-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < SPS_NCH; i++) begin
        chan_ff[i] <= SPS_OP_RST;
      end
      sum_ff <= SPS_OP_RST;
    end else begin
      chan_ff <= nxt_chan;
      sum_ff  <= nxt_sum;
    end
  end

  assign channel_a_scaled = chan_ff[SPS_POL_A_BIT];
  assign channel_b_scaled = chan_ff[SPS_POL_B_BIT];
  assign sum_result       = sum_ff;

  // ==========================================================
  // Checks
  // ==========================================================
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_wr_gain_a_high;
    psel && penable && pwrite && (paddr == SPS_OFF_GAINA) && ($signed(pwdata) > SPS_DW'(SPS_VAL_MAX));
  endsequence

  sequence s_a_unity;
    (gain_ff[0] == div_ff[0]) && (gain_ff[0] != '0)
      && (operand_ff[0] <= bound_ff) && (operand_ff[0] >= -bound_ff);
  endsequence

  sequence s_b_unity;
    (gain_ff[1] == div_ff[1]) && (gain_ff[1] != '0)
      && (operand_ff[1] <= bound_ff) && (operand_ff[1] >= -bound_ff);
  endsequence

  sequence s_wr_bound_high;
    psel && penable && pwrite && (paddr == SPS_OFF_BOUND) && ($signed(pwdata) > SPS_DW'(SPS_BOUND_MAX));
  endsequence

  sequence s_wr_opa_high;
    psel && penable && pwrite && (paddr == SPS_OFF_OPA) && ($signed(pwdata) > SPS_DW'(SPS_VAL_MAX));
  endsequence

  sequence s_wr_opc_low;
    psel && penable && pwrite && (paddr == SPS_OFF_OPC) && ($signed(pwdata) < SPS_DW'(SPS_VAL_MIN));
  endsequence

  sequence s_wr_pol;
    psel && penable && pwrite && (paddr == SPS_OFF_POL);
  endsequence

  sequence s_wr_to_result;
    psel && penable && pwrite && (paddr == SPS_OFF_SUM);
  endsequence

  // Decode is by exact match, so any unaligned or high place is unmapped
  sequence s_setup_unmapped;
    psel && !penable && ((paddr[1:0] != 2'h0) || (paddr > SPS_OFF_CHB));
  endsequence

  sequence s_rd_bound;
    psel && !penable && (paddr == SPS_OFF_BOUND);
  endsequence

  sequence s_rd_sum;
    psel && !penable && (paddr == SPS_OFF_SUM);
  endsequence

  property p_within_bound(spsum_val_t v);
    1'b1 |=> (v <= $past(bound_ff)) && (v >= -$past(bound_ff));
  endproperty

  chk_div_zero_a: assert property ((div_ff[0] == '0) |=> (channel_a_scaled == '0))
    else $error("channel a not zero after zero divisor");
  chk_div_zero_b: assert property ((div_ff[1] == '0) |=> (channel_b_scaled == '0))
    else $error("channel b not zero after zero divisor");
  chk_chan_a_bound: assert property (p_within_bound(channel_a_scaled))
    else $error("channel a outside bound");
  chk_sum_bound: assert property (p_within_bound(sum_result))
    else $error("sum outside bound");
  chk_unity_scale_a: assert property (s_a_unity |=> (channel_a_scaled == $past(operand_ff[0])))
    else $error("channel a wrong at unity ratio");
  chk_unity_scale_b: assert property (s_b_unity |=> (channel_b_scaled == $past(operand_ff[1])))
    else $error("channel b wrong at unity ratio");
  chk_c_direct_sum: assert property ((gain_ff[0] == '0) && (gain_ff[1] == '0)
      && (operand_c_ff <= bound_ff) && (operand_c_ff >= -bound_ff)
      |=> (sum_result == $past(operand_c_ff)))
    else $error("operand c not passed to sum");
  chk_polarity_neg: assert property (!pol_ff[0] && (gain_ff[1] == '0) && (operand_c_ff == '0)
      |=> (sum_result == -channel_a_scaled))
    else $error("negative polarity not applied");
  chk_gain_sat: assert property (s_wr_gain_a_high |=> (gain_ff[0] == SPS_VAL_MAX))
    else $error("gain write not saturated");
  chk_bound_range: assert property ((bound_ff >= SPS_BOUND_MIN) && (bound_ff <= SPS_BOUND_MAX))
    else $error("bound setting out of range");
  // First reset edge skipped: at time zero the registers may not have seen reset yet
  chk_reset_clear: assert property (@(posedge pclk) disable iff (1'b0)
      !presetn && $past(!presetn)
      |-> (sum_result == '0) && (channel_a_scaled == '0) && (channel_b_scaled == '0))
    else $error("outputs not cleared in reset");
  chk_chan_b_bound: assert property (p_within_bound(channel_b_scaled))
    else $error("channel b outside bound");
  chk_bound_sat: assert property (s_wr_bound_high |=> (bound_ff == SPS_BOUND_MAX))
    else $error("bound write not saturated");
  chk_opa_sat: assert property (s_wr_opa_high |=> (operand_ff[0] == SPS_VAL_MAX))
    else $error("operand a write not saturated");
  chk_opc_sat: assert property (s_wr_opc_low |=> (operand_c_ff == SPS_VAL_MIN))
    else $error("operand c write not saturated");
  chk_pol_write: assert property (s_wr_pol |=> (pol_ff == $past(pwdata[SPS_NCH-1:0])))
    else $error("polarity write lost");
  chk_ro_write: assert property (s_wr_to_result |=> $stable(bound_ff) && $stable(pol_ff) && $stable(operand_c_ff))
    else $error("result write changed a setting");
  chk_unmapped_err: assert property (s_setup_unmapped |=> pslverr && (prdata == SPS_DATA_ZERO))
    else $error("unmapped access not flagged");
  chk_err_access_only: assert property (pslverr |-> psel && penable)
    else $error("error flag outside access phase");
  chk_read_bound: assert property (s_rd_bound |=> (prdata == SPS_DW'($past(bound_ff))))
    else $error("bound read back wrong");
  chk_sum_read: assert property (s_rd_sum |=> (prdata == SPS_DW'($past(sum_result))))
    else $error("sum read back wrong");

endmodule
`default_nettype wire

// ---- testbench/spsum_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module spsum_test;
  import spsum_pkg::*;

  // ==========================================================
  // Signals
  // ==========================================================
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  spsum_addr_t paddr;
  spsum_data_t pwdata;
  logic        pready;
  logic        pslverr;
  spsum_data_t prdata;
  spsum_val_t  sum_result;
  spsum_val_t  channel_a_scaled;
  spsum_val_t  channel_b_scaled;
  int          num_errors;
  int          checks_done;
  int          cycles;
  logic [31:0] lfsr_ff;
  longint      val [9];
  spsum_addr_t regs [9] = '{SPS_OFF_OPA, SPS_OFF_OPB, SPS_OFF_OPC, SPS_OFF_GAINA, SPS_OFF_GAINB,
                            SPS_OFF_DIVA, SPS_OFF_DIVB, SPS_OFF_POL, SPS_OFF_BOUND};
  longint      rst [9]  = '{SPS_OP_RST, SPS_OP_RST, SPS_OP_RST, SPS_GAIN_RST, SPS_GAIN_RST,
                            SPS_DIV_RST, SPS_DIV_RST, SPS_POL_RST, SPS_BOUND_RST};
  longint      lo [9]   = '{-30000, -30000, -30000, -30000, -30000, -30000, -30000, 0, 0};
  longint      hi [9]   = '{30000, 30000, 30000, 30000, 30000, 30000, 30000, 3, 20000};

  spsum_top spsum_top_inst (
    .pclk             (pclk),
    .presetn          (presetn),
    .psel             (psel),
    .penable          (penable),
    .pwrite           (pwrite),
    .paddr            (paddr),
    .pwdata           (pwdata),
    .pready           (pready),
    .pslverr          (pslverr),
    .prdata           (prdata),
    .sum_result       (sum_result),
    .channel_a_scaled (channel_a_scaled),
    .channel_b_scaled (channel_b_scaled)
  );

  // ==========================================================
  // Clock and hang guard
  // ==========================================================
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // Whole run needs about 2700 cycles
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      stop_test();
    end
  end

  // ==========================================================
  // Helpers
  // ==========================================================
  task automatic stop_test();
    if (num_errors == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic longint rnd(input longint m);
    lfsr_ff = {lfsr_ff[30:0], lfsr_ff[31] ^ lfsr_ff[21] ^ lfsr_ff[1] ^ lfsr_ff[0]};
    return longint'(lfsr_ff % (2 * m + 1)) - m;
  endfunction

  function automatic longint clamp(input longint v, input longint l, input longint h);
    return (v > h) ? h : ((v < l) ? l : v);
  endfunction

  // Division truncates toward zero, as the design's does
  function automatic longint chan(input longint op, input longint g, input longint d, input longint b);
    return (d == 0) ? 0 : clamp(op * g / d, -b, b);
  endfunction

  // Holds the request until pready is seen high at a rising edge
  task automatic apb(input logic w, input spsum_addr_t a, input spsum_data_t d,
                     output spsum_data_t rd, output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic check_resets();
    spsum_data_t rd;
    logic        err;
    for (int k = 0; k < 9; k++) begin
      apb(1'b0, regs[k], SPS_DATA_ZERO, rd, err);
      check(rd, 32'(rst[k]));
    end
  endtask

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    spsum_data_t rd;
    logic        err;
    longint      v;
    longint      ca;
    longint      cb;
    longint      es;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    presetn = 1'b0;
    num_errors = 0;
    checks_done = 0;
    lfsr_ff = 32'hDF2FE783;
    repeat (8) @(posedge pclk);
    check(32'(sum_result), 32'h00000000);
    presetn <= 1'b1;
    check_resets();
    // Unmapped place and a read-only result register
    apb(1'b1, 8'h30, 32'h00001234, rd, err);
    check(32'(err), 32'h00000001);
    apb(1'b0, 8'h30, SPS_DATA_ZERO, rd, err);
    check(rd, 32'h00000000);
    check(32'(err), 32'h00000001);
    apb(1'b1, SPS_OFF_SUM, 32'h00001111, rd, err);
    apb(1'b0, SPS_OFF_SUM, SPS_DATA_ZERO, rd, err);
    check(rd, 32'h00000000);
    check(32'(err), 32'h00000000);
    for (int it = 0; it < 40; it++) begin
      for (int k = 0; k < 9; k++) begin
        v = (k == 7) ? longint'(lfsr_ff[1:0]) : ((k == 8) ? rnd(12000) + 9000 : rnd(40000));
        if ((k == 5 || k == 6) && lfsr_ff[4:2] == 3'h0) begin
          v = 0;
        end
        case (it)
          0: if (k == 8) v = 0;
          1: if (k < 7) v = (k == 5 || k == 6) ? 1 : 50000;
          2: if (k == 5 || k == 6) v = 0;
          3: if (k == 7) v = 0; else if (k < 3) v = -45000;
          4: if (k == 3 || k == 4) v = 0; else if (k == 2) v = -1234; else if (k == 8) v = 20000;
          5: if (k == 2 || k == 4) v = 0; else if (k == 7) v = 2;
          6: if (k == 3 || k == 5) v = 12345; else if (k == 4 || k == 6) v = -20000; else if (k != 2 && k != 7) v = 7000;
          default: ;
        endcase
        apb(1'b1, regs[k], 32'(v), rd, err);
        val[k] = clamp(v, lo[k], hi[k]);
      end
      for (int k = 0; k < 9; k++) begin
        apb(1'b0, regs[k], SPS_DATA_ZERO, rd, err);
        check(rd, 32'(val[k]));
      end
      repeat (2) @(posedge pclk);
      ca = chan(val[0], val[3], val[5], val[8]);
      cb = chan(val[1], val[4], val[6], val[8]);
      es = (val[7][0] ? ca : -ca) + (val[7][1] ? cb : -cb) + val[2];
      es = clamp(es, -val[8], val[8]);
      check(32'(channel_a_scaled), 32'(ca));
      check(32'(channel_b_scaled), 32'(cb));
      check(32'(sum_result), 32'(es));
      apb(1'b0, SPS_OFF_SUM, SPS_DATA_ZERO, rd, err);
      check(rd, 32'(es));
      apb(1'b0, SPS_OFF_CHA, SPS_DATA_ZERO, rd, err);
      check(rd, 32'(ca));
      apb(1'b0, SPS_OFF_CHB, SPS_DATA_ZERO, rd, err);
      check(rd, 32'(cb));
    end
    // Reset in mid-run clears both channel outputs and the settings
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    check(32'(channel_a_scaled), 32'h00000000);
    check(32'(channel_b_scaled), 32'h00000000);
    presetn <= 1'b1;
    check_resets();
    stop_test();
  end
endmodule
`default_nettype wire
